// file: design/wake_pkg.sv
package wake_pkg;
  // printed offsets are register indices; byte address is four times that
  localparam logic [7:0]  PR_IDX     = 8'h49;
  localparam logic [7:0]  CSR_IDX    = 8'h4A;
  localparam logic [11:0] PR_ADDR    = {2'h0, PR_IDX, 2'h0};
  localparam logic [11:0] CSR_ADDR   = {2'h0, CSR_IDX, 2'h0};
  localparam logic [11:0] ISTAT_ADDR = 12'h130;
  localparam logic [11:0] ICLR_ADDR  = 12'h134;
  localparam logic [11:0] IEN_ADDR   = 12'h138;
  // control/status fields
  localparam int          EN_BIT     = 0;
  localparam int          MEAS_BIT   = 1;
  localparam int          FLAG_BIT   = 2;
  localparam logic [7:0]  PR_RESET   = 8'hFF;
  localparam logic [7:0]  PR_ZERO    = 8'h00;
  localparam logic [1:0]  CSR_WMASK  = 2'h3;
  // interrupt event bits
  localparam int          EV_WAKE    = 0;
  localparam int          EV_EXIT    = 1;
  localparam logic [1:0]  EV_NONE    = 2'h0;
  // timing
  localparam int          CLK_MHZ    = 250;
  localparam logic [5:0]  FIX_LAST   = 6'h3F;
  localparam logic [19:0] STAB_SHORT = 20'h00100;
  localparam logic [19:0] STAB_LONG  = 20'h01000;
  localparam logic [19:0] CNT_ONE    = 20'h00001;

  typedef enum logic [2:0] {
    ST_RUN     = 3'h0,
    ST_RCSTART = 3'h1,
    ST_COUNT   = 3'h2,
    ST_HALT    = 3'h3,
    ST_STAB    = 3'h4,
    ST_PLL     = 3'h5
  } pstate_t;

  // requests and options from the core
  typedef struct packed {
    logic halt_exec;
    logic irq_pending;
    logic exit_irq;
    logic wdg_en;
    logic watchdog_halt_option;
    logic stab_long;
    logic pll_en;
  } core_in_t;

  // power and clock controls to the rest of the chip
  typedef struct packed {
    logic main_osc_en;
    logic periph_clk_en;
    logic cpu_resume;
    logic imask_clr;
    logic wdg_reset;
    logic rc_osc_en;
    logic capture_in;
    logic wake_irq;
  } pwr_out_t;
endpackage

// file: design/auto_wake_from_halt.sv
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/10ps
module auto_wake_from_halt #(
  parameter int RC_KHZ        = 32,
  parameter int RC_DIV        = (wake_pkg::CLK_MHZ * 1000) / RC_KHZ,
  parameter int RC_START_NS   = 50000,
  parameter int RC_START_CYC  = (RC_START_NS * wake_pkg::CLK_MHZ + 999) / 1000,
  parameter int PLL_START_NS  = 100000,
  parameter int PLL_START_CYC = (PLL_START_NS * wake_pkg::CLK_MHZ + 999) / 1000
) (
  // clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // ahb-lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  // core side
  input  wire wake_pkg::core_in_t core_in,
  output wake_pkg::pwr_out_t      pwr_out,
  output logic                    irq
);
  localparam logic [19:0] RC_LAST  = 20'(RC_DIV - 1);
  localparam logic [19:0] RC_HALF  = 20'(RC_DIV / 2);
  localparam logic [19:0] STRT_END = 20'(RC_START_CYC - 1);
  localparam logic [19:0] PLL_END  = 20'(PLL_START_CYC - 1);
  localparam logic [19:0] CNT_ONE  = wake_pkg::CNT_ONE;

  typedef struct packed {
    wake_pkg::pstate_t st;
    logic [7:0]        prescale;
    logic              wake_en;
    logic              meas;
    logic              flag;
    logic [1:0]        ist;
    logic [1:0]        ien;
    logic              wr_pend;
    logic [11:0]       wr_addr;
    logic [31:0]       rdata;
    logic [19:0]       rc_div;
    logic [5:0]        fix_cnt;
    logic [7:0]        pre_cnt;
    logic [19:0]       cnt;
    logic              capture;
    logic              resume;
    logic              imask_clr;
    logic              wdg_reset;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic        addr_ok;
  logic        rd_csr;
  logic        tick;
  logic        expire;
  logic        halted;
  logic        entry_ok;
  logic [19:0] stab_end;
  logic [31:0] rd_mux;

  // wake rc runs in timed halt or while measuring
  function automatic logic rc_on(input wake_pkg::pstate_t st,
                                 input logic meas);
    return meas || st == wake_pkg::ST_RCSTART
                || st == wake_pkg::ST_COUNT;
  endfunction

  // address phase qualifiers and state decodes
  assign addr_ok  = hsel && htrans[1] && hready;
  assign rd_csr   = addr_ok && !hwrite
                    && haddr[11:0] == wake_pkg::CSR_ADDR;
  assign halted   = s_q.st == wake_pkg::ST_RCSTART
                    || s_q.st == wake_pkg::ST_COUNT
                    || s_q.st == wake_pkg::ST_HALT;
  assign tick     = s_q.rc_div == RC_LAST;
  assign expire   = s_q.st == wake_pkg::ST_COUNT && tick
                    && s_q.fix_cnt == wake_pkg::FIX_LAST
                    && s_q.pre_cnt + 8'h01 == s_q.prescale;
  assign entry_ok = s_q.st == wake_pkg::ST_RUN && core_in.halt_exec
                    && !(core_in.wdg_en
                         && core_in.watchdog_halt_option);
  assign stab_end = core_in.stab_long ? wake_pkg::STAB_LONG - CNT_ONE
                                      : wake_pkg::STAB_SHORT - CNT_ONE;

  // read data picked in the address phase, held for the data phase
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (haddr[11:0])
      wake_pkg::PR_ADDR:    rd_mux[7:0] = s_q.prescale;
      wake_pkg::CSR_ADDR:
      begin
        rd_mux[wake_pkg::EN_BIT]   = s_q.wake_en;
        rd_mux[wake_pkg::MEAS_BIT] = s_q.meas;
        rd_mux[wake_pkg::FLAG_BIT] = s_q.flag;
      end
      wake_pkg::ISTAT_ADDR: rd_mux[1:0] = s_q.ist;
      wake_pkg::IEN_ADDR:   rd_mux[1:0] = s_q.ien;
      default:              rd_mux = 32'h0000_0000;
    endcase
  end

  // next state of the whole block
  always_comb
  begin
    s_d           = s_q;
    s_d.resume    = 1'b0;
    s_d.imask_clr = 1'b0;
    s_d.wdg_reset = 1'b0;
    s_d.wr_pend   = addr_ok && hwrite;
    s_d.wr_addr   = haddr[11:0];
    if (addr_ok && !hwrite)
    begin
      s_d.rdata = rd_mux;
    end

    // data phase write; flag bit is not writable
    if (s_q.wr_pend)
    begin
      case (s_q.wr_addr)
        wake_pkg::PR_ADDR:
        begin
          if (hwdata[7:0] != wake_pkg::PR_ZERO)
          begin
            s_d.prescale = hwdata[7:0];
          end
        end
        wake_pkg::CSR_ADDR:
        begin
          s_d.wake_en = hwdata[wake_pkg::EN_BIT];
          s_d.meas    = hwdata[wake_pkg::MEAS_BIT];
        end
        wake_pkg::ICLR_ADDR: s_d.ist = s_q.ist & ~hwdata[1:0];
        wake_pkg::IEN_ADDR:  s_d.ien = hwdata[1:0];
        default:             s_d.ien = s_q.ien;
      endcase
    end

    // read of control/status clears the wake request
    if (rd_csr)
    begin
      s_d.flag = 1'b0;
    end

    // rc divider is held at zero while the oscillator is off
    if (rc_on(s_q.st, s_q.meas) && !tick)
    begin
      s_d.rc_div = s_q.rc_div + CNT_ONE;
    end
    else
    begin
      s_d.rc_div = 20'h0_0000;
    end
    // capture sees the rc clock only in measurement while running
    s_d.capture = s_q.meas && s_q.st == wake_pkg::ST_RUN
                  && s_q.rc_div < RC_HALF;

    case (s_q.st)
      wake_pkg::ST_RUN:
      begin
        if (core_in.halt_exec)
        begin
          s_d.imask_clr = 1'b1;
          s_d.cnt       = 20'h0_0000;
          s_d.fix_cnt   = 6'h00;
          s_d.pre_cnt   = 8'h00;
          if (!entry_ok)
          begin
            s_d.wdg_reset = 1'b1;
          end
          else if (core_in.irq_pending)
          begin
            s_d.st = wake_pkg::ST_STAB;
          end
          else if (s_q.wake_en)
          begin
            s_d.st = wake_pkg::ST_RCSTART;
          end
          else
          begin
            s_d.st = wake_pkg::ST_HALT;
          end
        end
      end
      wake_pkg::ST_RCSTART:
      begin
        // oscillator start-up time before the first counted period
        s_d.cnt    = s_q.cnt + CNT_ONE;
        s_d.rc_div = 20'h0_0000;
        if (s_q.cnt >= STRT_END)
        begin
          s_d.st  = wake_pkg::ST_COUNT;
          s_d.cnt = 20'h0_0000;
        end
      end
      wake_pkg::ST_COUNT:
      begin
        if (tick)
        begin
          s_d.fix_cnt = s_q.fix_cnt + 6'h01;
          if (s_q.fix_cnt == wake_pkg::FIX_LAST)
          begin
            s_d.pre_cnt = s_q.pre_cnt + 8'h01;
          end
        end
        if (expire)
        begin
          s_d.flag           = 1'b1;
          s_d.ist[wake_pkg::EV_WAKE] = 1'b1;
          s_d.st             = wake_pkg::ST_STAB;
        end
      end
      wake_pkg::ST_HALT:
      begin
        s_d.st = s_q.st;
      end
      wake_pkg::ST_STAB:
      begin
        s_d.cnt = s_q.cnt + CNT_ONE;
        if (s_q.cnt >= stab_end)
        begin
          s_d.cnt = 20'h0_0000;
          if (core_in.pll_en)
          begin
            s_d.st = wake_pkg::ST_PLL;
          end
          else
          begin
            s_d.st     = wake_pkg::ST_RUN;
            s_d.resume = 1'b1;
          end
        end
      end
      wake_pkg::ST_PLL:
      begin
        s_d.cnt = s_q.cnt + CNT_ONE;
        if (s_q.cnt >= PLL_END)
        begin
          s_d.st     = wake_pkg::ST_RUN;
          s_d.resume = 1'b1;
          s_d.cnt    = 20'h0_0000;
        end
      end
      default: s_d.st = wake_pkg::ST_RUN;
    endcase

    // any halt-exit interrupt ends halt; timer expiry has priority
    if (halted && core_in.exit_irq && !expire)
    begin
      s_d.st  = wake_pkg::ST_STAB;
      s_d.cnt = 20'h0_0000;
      s_d.ist[wake_pkg::EV_EXIT] = 1'b1;
    end
    // a clear write and a new event in one cycle: the event wins
    if (expire)
    begin
      s_d.ist[wake_pkg::EV_WAKE] = 1'b1;
    end
  end

  // single register for all state except the check counters below
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_q          <= '0;
      s_q.st       <= wake_pkg::ST_RUN;
      s_q.prescale <= wake_pkg::PR_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // bus answers: zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = s_q.rdata;
  assign irq       = |(s_q.ist & s_q.ien);

  // clock gating decided by power state
  always_comb
  begin
    pwr_out               = '0;
    pwr_out.main_osc_en   = !halted;
    pwr_out.periph_clk_en = s_q.st == wake_pkg::ST_RUN;
    pwr_out.cpu_resume    = s_q.resume;
    pwr_out.imask_clr     = s_q.imask_clr;
    pwr_out.wdg_reset     = s_q.wdg_reset;
    pwr_out.rc_osc_en     = rc_on(s_q.st, s_q.meas);
    pwr_out.capture_in    = s_q.capture;
    pwr_out.wake_irq      = s_q.flag;
  end

  // helper counters that only the checks read
  logic [13:0] tick_seen_q;
  logic [19:0] stab_seen_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tick_seen_q <= 14'h0000;
      stab_seen_q <= 20'h0_0000;
    end
    else
    begin
      if (s_q.st != wake_pkg::ST_COUNT)
        tick_seen_q <= 14'h0000;
      else if (tick)
        tick_seen_q <= tick_seen_q + 14'h0001;
      if (s_q.st != wake_pkg::ST_STAB)
        stab_seen_q <= 20'h0_0000;
      else
        stab_seen_q <= stab_seen_q + CNT_ONE;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  timed_entry_a: assert property (
    entry_ok && !core_in.irq_pending && s_q.wake_en
    |=> s_q.st == wake_pkg::ST_RCSTART && pwr_out.rc_osc_en
  ) else $error("timed halt not entered");

  delay_len_a: assert property (
    expire |-> tick_seen_q == {s_q.prescale, 6'h00} - 14'h0001
  ) else $error("wake delay length wrong");

  flag_set_a: assert property (
    expire |=> pwr_out.wake_irq && s_q.st == wake_pkg::ST_STAB
  ) else $error("expiry did not set flag");

  stab_len_a: assert property (
    s_q.st == wake_pkg::ST_STAB && s_d.st != wake_pkg::ST_STAB
    && !core_in.exit_irq |-> stab_seen_q == stab_end
  ) else $error("stabilisation length wrong");

  read_clear_a: assert property (
    rd_csr && !expire |=> !pwr_out.wake_irq
  ) else $error("csr read left flag set");

  flag_hold_a: assert property (
    s_q.wr_pend && !rd_csr && !expire && s_q.st != wake_pkg::ST_COUNT
    |=> pwr_out.wake_irq == $past(pwr_out.wake_irq)
  ) else $error("write changed flag");

  meas_osc_a: assert property (
    s_q.meas |-> pwr_out.rc_osc_en
  ) else $error("measure without oscillator");

  exit_irq_a: assert property (
    halted && core_in.exit_irq |=> s_q.st == wake_pkg::ST_STAB
  ) else $error("halt exit interrupt ignored");

  osc_off_a: assert property (
    halted |-> !pwr_out.main_osc_en && !pwr_out.periph_clk_en
  ) else $error("clocks running in halt");

  wdg_halt_a: assert property (
    s_q.st == wake_pkg::ST_RUN && core_in.halt_exec
    && core_in.wdg_en && core_in.watchdog_halt_option
    |=> pwr_out.wdg_reset && s_q.st == wake_pkg::ST_RUN
  ) else $error("watchdog halt reset missing");

  timed_wake_c: cover property (
    expire ##[1:300] pwr_out.cpu_resume);
  exit_wake_c: cover property (
    halted && core_in.exit_irq);
  measure_c: cover property (
    s_q.meas && pwr_out.capture_in);
endmodule // auto_wake_from_halt

// file: sim/tb.sv
`timescale 1ns/10ps
module tb;
  typedef struct packed {
    logic [1:0]  sel;
    logic [31:0] mask;
    logic [31:0] exp;
  } note_t;
  typedef struct packed {
    int lo;
    int hi;
  } span_t;

  localparam int          DIV    = 4;
  localparam int          RCS    = 4;
  localparam int          PLLS   = 4;
  localparam logic [31:0] A_PR   = {20'h0, wake_pkg::PR_ADDR};
  localparam logic [31:0] A_CSR  = {20'h0, wake_pkg::CSR_ADDR};
  localparam logic [31:0] A_IST  = {20'h0, wake_pkg::ISTAT_ADDR};
  localparam logic [31:0] A_ICLR = {20'h0, wake_pkg::ICLR_ADDR};
  localparam logic [31:0] A_IEN  = {20'h0, wake_pkg::IEN_ADDR};
  localparam logic [31:0] M_IRQ  = 32'h100;
  localparam logic [31:0] M_OSC  = 32'h80;
  localparam logic [31:0] M_PER  = 32'h40;
  localparam logic [31:0] M_IMC  = 32'h10;
  localparam logic [31:0] M_WDG  = 32'h8;
  localparam logic [31:0] M_RC   = 32'h4;
  localparam logic [31:0] M_WIRQ = 32'h1;

  logic               hclk;
  logic               hresetn;
  logic               hsel;
  logic [31:0]        haddr;
  logic [1:0]         htrans;
  logic [2:0]         hsize;
  logic               hwrite;
  logic [31:0]        hwdata;
  logic               hreadyout;
  logic               hresp;
  logic [31:0]        hrdata;
  wake_pkg::core_in_t core_in;
  wake_pkg::pwr_out_t pwr_out;
  logic               irq;
  logic [7:0]         cap_sr;
  logic [31:0]        seed;
  int                 n_fail;
  int                 num_checks;
  int                 cyc;
  note_t              note_q[$];
  span_t              span_q[$];

  // long counts shortened so a wake with short stabilisation fits in about a thousand cycles
  auto_wake_from_halt #(
    .RC_DIV       (DIV),
    .RC_START_CYC (RCS),
    .PLL_START_CYC(PLLS)
  ) auto_wake_from_halt_i (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .hsel     (hsel),
    .haddr    (haddr),
    .htrans   (htrans),
    .hwrite   (hwrite),
    .hsize    (hsize),
    .hwdata   (hwdata),
    .hready   (hreadyout),
    .hreadyout(hreadyout),
    .hresp    (hresp),
    .hrdata   (hrdata),
    .core_in  (core_in),
    .pwr_out  (pwr_out),
    .irq      (irq)
  );

  // clock
  initial hclk = 1'b0;
  always #2 hclk = ~hclk;

  // cycles since the halt request was sampled
  always @(posedge hclk)
    cyc <= core_in.halt_exec ? 0 : cyc + 1;

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // observer samples mid-cycle, away from the launching edge
  always @(negedge hclk)
  begin
    note_t n;
    span_t s;
    cap_sr <= {cap_sr[6:0], pwr_out.capture_in};
    if (note_q.size() != 0)
    begin
      n = note_q.pop_front();
      case (n.sel)
        2'h1:
        begin
          chk("hrdata", hrdata & n.mask, n.exp);
          chk("hresp", {31'h0, hresp}, 32'h0);
        end
        2'h2: chk("outputs", {23'h0, irq, pwr_out} & n.mask, n.exp);
        default: chk("capture_highs", 32'($countones(cap_sr)), n.exp);
      endcase
    end
    if (pwr_out.cpu_resume === 1'b1)
    begin
      s = span_q.pop_front();
      chk("wake_cycles", 32'(cyc >= s.lo && cyc <= s.hi), 32'h1);
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic note(input logic [1:0] s, input logic [31:0] m,
                      input logic [31:0] e);
    note_q.push_back('{s, m, e});
    @(posedge hclk);
  endtask

  task automatic addr_ph(input logic [31:0] a, input logic w);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hsize  <= 3'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    addr_ph(a, 1'b1);
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    addr_ph(a, 1'b0);
    // data phase: the observer compares hrdata while it stands
    note_q.push_back('{2'h1, 32'hFFFFFFFF, e});
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic halt(input int lo, input int hi);
    core_in.halt_exec <= 1'b1;
    @(posedge hclk);
    core_in.halt_exec <= 1'b0;
    if (hi > 0)
      span_q.push_back('{lo, hi});
  endtask

  // bounded wait; the resume pulse itself is judged by the observer
  task automatic wait_resume();
    int i;
    for (i = 0; i < 9000 && pwr_out.cpu_resume !== 1'b1; i++)
      @(negedge hclk);
    if (i == 9000)
      n_fail++;
    @(posedge hclk);
  endtask

  task automatic test_done();
    if (n_fail == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // hang guard, well above the longest wake sequence
  initial
  begin
    #(4 * 40000);
    n_fail++;
    test_done();
  end

  // main sequence
  initial
  begin
    logic [7:0] pr;
    int         dly;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hsize = 3'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    core_in = '0;
    n_fail = 0;
    num_checks = 0;
    seed = 32'hE1A6DD59;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    note(2'h2, 32'h1FD, M_OSC | M_PER);
    rd(A_CSR, 32'h0);
    rd(A_PR, 32'hFF);
    wr(A_PR, 32'h0);
    rd(A_PR, 32'hFF);
    seed = lfsr(seed);
    wr(A_PR, {24'h0, seed[7:1], 1'b1});
    rd(A_PR, {24'h0, seed[7:1], 1'b1});
    wr(32'h100 | {27'h0, seed[4:2], 2'h0}, seed);
    rd(32'h100 | {27'h0, seed[4:2], 2'h0}, 32'h0);
    // flag position ignores writes; measure runs the oscillator
    wr(A_CSR, 32'hFF);
    rd(A_CSR, 32'h3);
    note(2'h2, M_RC, M_RC);
    repeat (9) @(posedge hclk);
    note(2'h3, 32'h0, 32'h4);
    wr(A_CSR, 32'h0);
    repeat (9) @(posedge hclk);
    note(2'h3, 32'h0, 32'h0);
    note(2'h2, M_RC, 32'h0);
    // timed wake with short, pll and long stabilisation
    wr(A_IEN, 32'h3);
    core_in.wdg_en <= 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      seed = lfsr(seed);
      pr = {6'h0, seed[1:0]} | 8'h01;
      core_in.pll_en <= (k == 1);
      core_in.stab_long <= (k == 2);
      wr(A_PR, {24'h0, pr});
      wr(A_CSR, 32'h1);
      dly = RCS + 64 * int'(pr) * DIV + 1 + ((k == 2) ? 4096 : 256);
      dly = dly + ((k == 1) ? PLLS : 0);
      halt(dly - 2, dly + 6);
      note(2'h2, M_IMC, M_IMC);
      repeat (2) @(posedge hclk);
      note(2'h2, M_OSC | M_PER | M_RC | M_WIRQ, M_RC);
      wait_resume();
      note(2'h2, M_IRQ | M_WIRQ | M_OSC | M_PER, 32'h1C1);
      rd(A_IST, 32'h1);
      rd(A_CSR, 32'h5);
      rd(A_CSR, 32'h1);
      note(2'h2, M_WIRQ, 32'h0);
      wr(A_IEN, 32'h2);
      @(posedge hclk);
      note(2'h2, M_IRQ, 32'h0);
      wr(A_IEN, 32'h3);
      wr(A_ICLR, 32'h1);
      @(posedge hclk);
      note(2'h2, M_IRQ, 32'h0);
      rd(A_IST, 32'h0);
    end
    // another interrupt ends timed and plain halt alike
    core_in.pll_en <= 1'b0;
    core_in.stab_long <= 1'b0;
    wr(A_PR, 32'hFF);
    for (int e = 1; e >= 0; e--)
    begin
      wr(A_CSR, 32'(e));
      halt(20 + 256 - 2, 20 + 256 + 8);
      repeat (3) @(posedge hclk);
      note(2'h2, M_RC | M_OSC, (e == 1) ? M_RC : 32'h0);
      repeat (15) @(posedge hclk);
      core_in.exit_irq <= 1'b1;
      wait_resume();
      core_in.exit_irq <= 1'b0;
      rd(A_IST, 32'h2);
      rd(A_CSR, 32'(e));
      wr(A_ICLR, 32'h3);
    end
    // pending interrupt skips the halt
    wr(A_CSR, 32'h1);
    core_in.irq_pending <= 1'b1;
    halt(254, 266);
    wait_resume();
    core_in.irq_pending <= 1'b0;
    // watchdog option turns halt into a reset request
    core_in.watchdog_halt_option <= 1'b1;
    halt(0, 0);
    note(2'h2, M_WDG | M_OSC, M_WDG | M_OSC);
    repeat (3) @(posedge hclk);
    note(2'h2, M_OSC | M_WDG, M_OSC);
    test_done();
  end
endmodule // tb
